// file: spf_cfg.svh
/*
 Constants for the self-programming flash sequencer: control bit
 positions, command codes, geometry and timing.
 Assumes inclusion by bare name from the package and the modules.
*/
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH

// Register map (word index on the plain register port)
`define SPF_ADDR_CTRL      4'h0
`define SPF_ADDR_CONFIG    4'h1
`define SPF_ADDR_POINTER   4'h2
`define SPF_ADDR_DATA      4'h3
`define SPF_ADDR_REGION    4'h4

// Control bit positions
`define SPF_BIT_OP_EN      0
`define SPF_BIT_ERASE      1
`define SPF_BIT_WRITE      2
`define SPF_BIT_LOCK       3
`define SPF_BIT_REEN       4
`define SPF_BIT_BUSY       6

// Command codes; bit 7 ignored, bit 6 is the read-only busy flag and must
// not take part in decoding or a re-enable issued while busy never matches
`define SPF_CMD_MASK       8'h3F
`define SPF_CMD_LOAD       8'h01
`define SPF_CMD_ERASE      8'h03
`define SPF_CMD_WRITE      8'h05
`define SPF_CMD_LOCK       8'h09
`define SPF_CMD_REEN       8'h11

// Geometry
`define SPF_PC_W           13
`define SPF_WORD_W         6
`define SPF_PAGE_W         7
`define SPF_SAFE_FIRST_PG  7'h70
`define SPF_BOOT_128       13'h1F80
`define SPF_BOOT_256       13'h1F00
`define SPF_BOOT_512       13'h1E00
`define SPF_BOOT_1024      13'h1C00

// Pointer field positions
`define SPF_Z_PAGE_HI      13
`define SPF_Z_PAGE_LO      7
`define SPF_Z_WORD_HI      6
`define SPF_Z_WORD_LO      1
`define SPF_Z_BYTE         0

// Timing
`define SPF_CLK_HZ         25000000
`define SPF_OP_MIN_US      3700
`define SPF_OP_MAX_US      4500
`define SPF_SPM_WINDOW     4

`endif

// file: spf_pkg.sv
/*
 Types shared by the flash sequencer modules.
 Assumes spf_cfg.svh for the numeric constants.
*/
`include "spf_cfg.svh"
package spf_pkg;
   typedef enum logic [1:0] {
      SPF_IDLE  = 2'b00,
      SPF_ARMED = 2'b01,
      SPF_BUSY  = 2'b11
   } spf_state_t;

   typedef enum logic [2:0] {
      SPF_OP_NONE,
      SPF_OP_LOAD,
      SPF_OP_ERASE,
      SPF_OP_WRITE,
      SPF_OP_LOCK,
      SPF_OP_REEN
   } spf_op_t;
endpackage

// file: spf_buf_if.sv
/*
 Carrier between sequencer and temporary page buffer.
 Assumes one clock domain.
*/
`timescale 1ns/10ps
interface spf_buf_if;
   logic        wr;
   logic        clr;
   logic [5:0]  word;
   logic [15:0] wdata;
   logic [5:0]  rword;
   logic [15:0] rdata;
   modport seq (output wr, clr, word, wdata, rword, input rdata);
   modport buff (input wr, clr, word, wdata, rword, output rdata);
endinterface

// file: spf_page_buf.sv
/*
 Temporary page buffer: one word per entry with a valid bit.
 Assumes the sequencer drives clear and load pulses on the same clock.
*/
`timescale 1ns/10ps
`include "spf_cfg.svh"
module spf_page_buf
   import spf_pkg::*;
#(
   parameter int WORDS = 64
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n,
   // Sequencer side
   spf_buf_if.buff   bus
);
   // Depth is tied to the word select field
   if (WORDS != (1 << `SPF_WORD_W)) begin : g_bad_words
      $error("spf_page_buf: WORDS must match the word select width");
   end

   logic [15:0] mem [WORDS];
   logic [WORDS-1:0] valid;
   logic [WORDS-1:0] next_valid;

   // Erased entries read as all ones
   assign bus.rdata = valid[bus.rword] ? mem[bus.rword] : 16'hFFFF;

   always_comb begin
      next_valid = valid;
      if (bus.clr) begin
         next_valid = '0;
      end else if (bus.wr) begin
         next_valid[bus.word] = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         valid <= '0;
      end else begin
         valid <= next_valid;
      end
   end

   // Each entry writable once until the buffer is cleared
   always_ff @(posedge clk_i) begin
      if (bus.wr && !bus.clr && !valid[bus.word]) begin
         mem[bus.word] <= bus.wdata;
      end
   end
endmodule

// file: spf_seq.sv
/*
 Self-programming flash sequencer: control register, timed operations,
 boot and read-while-write region decode, page buffer control.
 Assumes the CPU writes the control register, then pulses spm_exec_i within
 four clocks; flash array is outside and obeys the op strobes.
*/
`timescale 1ns/10ps
`include "spf_cfg.svh"
module spf_seq
   import spf_pkg::*;
#(
   parameter int OP_CYCLES = (`SPF_OP_MIN_US * (`SPF_CLK_HZ / 1000000)
                              + `SPF_OP_MAX_US * (`SPF_CLK_HZ / 1000000)) / 2
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // Register port
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [15:0]      rdata_o,
   // CPU side
   input  wire logic        spm_exec_i,
   input  wire logic        eeprom_write_active_i,
   input  wire logic [12:0] fetch_addr_i,
   output logic             fetch_allowed_o,
   output logic             lock_write_o,
   // Flash array side
   output logic             flash_erase_o,
   output logic             flash_write_o,
   output logic [6:0]       flash_page_o,
   output logic [12:0]      boot_start_o,
   output logic [7:0]       lock_data_o
);
   localparam int MAX_CYC = (`SPF_OP_MAX_US * (`SPF_CLK_HZ / 1000000));
   // Short lengths stay legal so a bench can run the timed path quickly
   if (OP_CYCLES < 2 || OP_CYCLES > MAX_CYC) begin : g_bad_op_cycles
      $error("spf_seq: OP_CYCLES out of range");
   end

   // Reset release through two flops
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // EEPROM flag comes from another block; synchronise
   logic ee_s1;
   logic ee_s2;
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ee_s1 <= 1'b0;
         ee_s2 <= 1'b0;
      end else begin
         ee_s1 <= eeprom_write_active_i;
         ee_s2 <= ee_s1;
      end
   end

   spf_buf_if bif ();
   spf_page_buf #(.WORDS(1 << `SPF_WORD_W)) u_buf (
      .clk_i (clk_i),
      .rst_n (rst_n),
      .bus   (bif)
   );

   spf_state_t  state;
   spf_state_t  next_state;
   logic [7:0]  ctrl;
   logic [7:0]  next_ctrl;
   logic [1:0]  boot_size;
   logic [1:0]  next_boot_size;
   logic [15:0] pointer;
   logic [15:0] next_pointer;
   logic [15:0] data;
   logic [15:0] next_data;
   logic        busy;
   logic        next_busy;
   logic [2:0]  win;
   logic [2:0]  next_win;
   logic [22:0] cnt;
   logic [22:0] next_cnt;
   spf_op_t     op;
   spf_op_t     next_op;
   logic [15:0] next_rdata;
   logic        next_fetch_ok;
   logic [12:0] next_boot_start;
   logic        buf_wr;
   logic        buf_clr;
   logic        start;
   logic [7:0]  cmd;

   // Word select for loads, pointer bit 0 unused by stores
   // word from pointer
   assign bif.word  = pointer[`SPF_Z_WORD_HI:`SPF_Z_WORD_LO];
   assign bif.wdata = data;
   assign bif.rword = pointer[`SPF_Z_WORD_HI:`SPF_Z_WORD_LO];
   assign bif.wr    = buf_wr;
   assign bif.clr   = buf_clr;
   assign cmd       = ctrl & `SPF_CMD_MASK;

   always_comb begin
      next_state     = state;
      next_ctrl      = ctrl;
      next_boot_size = boot_size;
      next_pointer   = pointer;
      next_data      = data;
      next_busy      = busy;
      next_win       = win;
      next_cnt       = cnt;
      next_op        = op;
      buf_wr         = 1'b0;
      buf_clr        = 1'b0;
      start          = 1'b0;
      // EEPROM write in progress blocks command writes
      if (wr_i && addr_i == `SPF_ADDR_CTRL && state == SPF_IDLE && !ee_s2) begin
         next_ctrl  = wdata_i[7:0];
         next_ctrl[`SPF_BIT_BUSY] = busy;
         next_state = wdata_i[`SPF_BIT_OP_EN] ? SPF_ARMED : SPF_IDLE;
         next_win   = 3'(`SPF_SPM_WINDOW);
      end else if (wr_i && addr_i == `SPF_ADDR_CONFIG) begin
         next_boot_size = wdata_i[1:0];
      end else if (wr_i && addr_i == `SPF_ADDR_POINTER) begin
         next_pointer = wdata_i;
      end else if (wr_i && addr_i == `SPF_ADDR_DATA) begin
         next_data = wdata_i;
      end
      case (state)
         SPF_ARMED: begin
            if (spm_exec_i) begin
               start = 1'b1;
            end else if (win == 3'h1) begin
               next_state = SPF_IDLE;
               next_ctrl[`SPF_BIT_OP_EN] = 1'b0;
            end else begin
               next_win = win - 3'h1;
            end
            if (start) begin
               next_state = SPF_IDLE;
               next_ctrl[`SPF_BIT_OP_EN] = 1'b0;
               if (cmd == `SPF_CMD_LOAD) begin
                  buf_wr = 1'b1;
               end else if (cmd == `SPF_CMD_REEN) begin
                  next_busy = 1'b0;
                  buf_clr = 1'b1;
               end else if (cmd == `SPF_CMD_ERASE || cmd == `SPF_CMD_WRITE
                            || cmd == `SPF_CMD_LOCK) begin
                  next_state = SPF_BUSY;
                  next_ctrl[`SPF_BIT_OP_EN] = 1'b1;
                  next_cnt   = 23'(OP_CYCLES - 1);
                  next_op    = (cmd == `SPF_CMD_ERASE) ? SPF_OP_ERASE :
                               (cmd == `SPF_CMD_WRITE) ? SPF_OP_WRITE : SPF_OP_LOCK;
                  if (cmd != `SPF_CMD_LOCK) begin
                     next_busy = 1'b1;
                  end
               end
            end
         end
         SPF_BUSY: begin
            if (cnt == 23'h0) begin
               next_state = SPF_IDLE;
               next_op    = SPF_OP_NONE;
               next_ctrl[`SPF_BIT_OP_EN] = 1'b0;
               if (op == SPF_OP_WRITE) begin
                  buf_clr = 1'b1;
               end
            end else begin
               next_cnt = cnt - 23'h1;
            end
         end
         default: begin
            next_state = next_state;
         end
      endcase
      next_ctrl[`SPF_BIT_BUSY] = next_busy;
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state     <= SPF_IDLE;
         ctrl      <= 8'h00;
         boot_size <= 2'h0;
         pointer   <= 16'h0000;
         data      <= 16'h0000;
         busy      <= 1'b0;
         win       <= 3'h0;
         cnt       <= 23'h0;
         op        <= SPF_OP_NONE;
      end else begin
         state     <= next_state;
         ctrl      <= next_ctrl;
         boot_size <= next_boot_size;
         pointer   <= next_pointer;
         data      <= next_data;
         busy      <= next_busy;
         win       <= next_win;
         cnt       <= next_cnt;
         op        <= next_op;
      end
   end

   // Output decode and read path
   always_comb begin
      next_boot_start = `SPF_BOOT_1024;
      case (boot_size)
         2'b11:   next_boot_start = `SPF_BOOT_128;
         2'b10:   next_boot_start = `SPF_BOOT_256;
         2'b01:   next_boot_start = `SPF_BOOT_512;
         default: next_boot_start = `SPF_BOOT_1024;
      endcase
      next_fetch_ok = !(op == SPF_OP_ERASE || op == SPF_OP_WRITE)
                      || (fetch_addr_i[`SPF_PC_W-1:`SPF_WORD_W] >= `SPF_SAFE_FIRST_PG);
      next_rdata = 16'h0000;
      if (!rd_i) begin
         next_rdata = 16'h0000;
      end else if (addr_i == `SPF_ADDR_CTRL) begin
         next_rdata = {8'h00, ctrl};
      end else if (addr_i == `SPF_ADDR_CONFIG) begin
         next_rdata = {14'h0000, boot_size};
      end else if (addr_i == `SPF_ADDR_POINTER) begin
         next_rdata = pointer;
      end else if (addr_i == `SPF_ADDR_DATA) begin
         next_rdata = pointer[`SPF_Z_BYTE] ? {8'h00, bif.rdata[15:8]}
                                           : {8'h00, bif.rdata[7:0]};
      end else if (addr_i == `SPF_ADDR_REGION) begin
         next_rdata = {3'h0, next_boot_start};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o         <= 16'h0000;
         fetch_allowed_o <= 1'b1;
         flash_erase_o   <= 1'b0;
         flash_write_o   <= 1'b0;
         lock_write_o    <= 1'b0;
         flash_page_o    <= 7'h00;
         boot_start_o    <= `SPF_BOOT_1024;
         lock_data_o     <= 8'hFF;
      end else begin
         rdata_o         <= next_rdata;
         fetch_allowed_o <= next_fetch_ok;
         flash_erase_o   <= (next_op == SPF_OP_ERASE);
         flash_write_o   <= (next_op == SPF_OP_WRITE);
         lock_write_o    <= (next_op == SPF_OP_LOCK);
         flash_page_o    <= pointer[`SPF_Z_PAGE_HI:`SPF_Z_PAGE_LO];
         boot_start_o    <= next_boot_start;
         lock_data_o     <= data[7:0];
      end
   end
endmodule

// file: spf_cpu_model.sv
/*
 CPU core model: issues the store-program pulse after a control write.
 Assumes the bench drives the register port and picks the delay.
*/
`timescale 1ns/10ps
`include "spf_cfg.svh"
module spf_cpu_model (
   // Clock
   input  wire logic        clk_i,
   // Observed register port
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   // Delay in clocks, zero skips the pulse
   input  wire logic [2:0]  dly_i,
   output logic             spm_exec_o
);
   logic [2:0] cnt;
   initial begin
      cnt = 3'h0;
      spm_exec_o = 1'b0;
   end
   // pulse follows an armed write after dly_i clocks
   always @(posedge clk_i) begin
      spm_exec_o <= 1'b0;
      if (wr_i && addr_i == `SPF_ADDR_CTRL && wdata_i[0] && dly_i != 3'h0) begin
         cnt <= dly_i;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
         spm_exec_o <= (cnt == 3'h1);
      end
   end
endmodule

// file: spf_seq_sva.sv
/*
 Port checker for the flash sequencer.
 Assumes binding to spf_seq and one clock domain.
*/
`timescale 1ns/10ps
`include "spf_cfg.svh"
module spf_seq_sva
   import spf_pkg::*;
#(
   parameter int OP_CYCLES = 20
) (
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic [3:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic        spm_exec_i,
   input wire logic [12:0] fetch_addr_i,
   input wire logic        fetch_allowed_o,
   input wire logic        lock_write_o,
   input wire logic        flash_erase_o,
   input wire logic        flash_write_o,
   input wire logic [6:0]  flash_page_o,
   input wire logic [12:0] boot_start_o,
   input wire logic [7:0]  lock_data_o
);
   logic [15:0] ptr;
   logic [15:0] dat;
   logic [1:0]  bsz;
   int          cnt;
   wire         pgop = flash_erase_o | flash_write_o;
   wire         op   = pgop | lock_write_o;
   wire         top  = (fetch_addr_i[12:10] == 3'h7);
   function automatic logic [12:0] bmap(input logic [1:0] s);
      return 13'(14'h2000 - (14'h0080 << (2'd3 - s)));
   endfunction
   // Shadow of the pointer, data and size fields as software wrote them
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ptr <= 16'h0000;
         dat <= 16'h0000;
         bsz <= 2'h0;
         cnt <= 0;
      end else begin
         if (wr_i && addr_i == `SPF_ADDR_POINTER) ptr <= wdata_i;
         if (wr_i && addr_i == `SPF_ADDR_DATA) dat <= wdata_i;
         if (wr_i && addr_i == `SPF_ADDR_CONFIG) bsz <= wdata_i[1:0];
         cnt <= op ? cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   page_sel_a: assert property (pgop |-> flash_page_o == ptr[13:7])
      else $error("flash page differs from pointer page field");
   op_len_a: assert property ($fell(op) |-> cnt >= OP_CYCLES && cnt <= OP_CYCLES + 1)
      else $error("timed operation length wrong");
   op_start_a: assert property ($rose(op) |-> $past(spm_exec_i))
      else $error("operation started without store pulse");
   fetch_ok_a: assert property (top |=> fetch_allowed_o)
      else $error("fetch from boot-safe pages refused");
   fetch_block_a: assert property (pgop && !top ##1 pgop |-> !fetch_allowed_o)
      else $error("lower-region fetch allowed during programming");
   boot_start_a: assert property
      (!$past(wr_i && addr_i == `SPF_ADDR_CONFIG) |-> boot_start_o == bmap(bsz))
      else $error("boot start does not match size setting");
   lock_data_a: assert property (lock_write_o |-> lock_data_o == dat[7:0])
      else $error("lock data differs from data register");
   busy_read_a: assert property
      (rd_i && addr_i == `SPF_ADDR_CTRL && pgop |=> rdata_o[`SPF_BIT_BUSY])
      else $error("busy flag clear during page operation");
   en_read_a: assert property
      (rd_i && addr_i == `SPF_ADDR_CTRL && op ##1 op |-> rdata_o[`SPF_BIT_OP_EN])
      else $error("enable bit clear during operation");
   cover property ($rose(flash_erase_o));
   cover property ($rose(flash_write_o));
   cover property ($rose(lock_write_o));
endmodule
bind spf_seq spf_seq_sva #(.OP_CYCLES(OP_CYCLES)) u_spf_seq_sva (
   .clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .spm_exec_i,
   .fetch_addr_i, .fetch_allowed_o, .lock_write_o, .flash_erase_o,
   .flash_write_o, .flash_page_o, .boot_start_o, .lock_data_o
);

// file: self_program_flash_addressing_tb.sv
/*
 Self-checking bench for the flash sequencer.
 Assumes a short op length and the CPU model as partner.
*/
`timescale 1ns/10ps
`include "spf_cfg.svh"
module self_program_flash_addressing_tb;
   import spf_pkg::*;
   localparam int OPC = 20;
   logic        clk_i, nrst_i, wr_i, rd_i, spm_exec_i, ee;
   logic [3:0]  addr_i;
   logic [15:0] wdata_i, rdata_o, d;
   logic [12:0] fetch_addr_i, boot_start_o;
   logic        fetch_allowed_o, lock_write_o, flash_erase_o, flash_write_o;
   logic [6:0]  flash_page_o;
   logic [7:0]  lock_data_o;
   logic [2:0]  dly;
   int          err_count, n_compared;
   spf_seq #(.OP_CYCLES(OPC)) u_spf_seq (
      .clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .spm_exec_i,
      .eeprom_write_active_i(ee), .fetch_addr_i, .fetch_allowed_o, .lock_write_o,
      .flash_erase_o, .flash_write_o, .flash_page_o, .boot_start_o, .lock_data_o
   );
   spf_cpu_model u_spf_cpu_model (
      .clk_i, .addr_i, .wdata_i, .wr_i, .dly_i(dly), .spm_exec_o(spm_exec_i)
   );
   always #20 clk_i = ~clk_i;
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      @(negedge clk_i);
      v = rdata_o;
   endtask
   task automatic poll_idle();
      int i;
      for (i = 0; i < 4 * OPC; i++) begin
         rd(`SPF_ADDR_CTRL, d);
         if (d[`SPF_BIT_OP_EN] === 1'b0) break;
      end
      if (i == 4 * OPC) begin
         err_count++;
         $display("[FAIL] %0t wait for idle ran out", $time);
         conclude();
      end
   endtask
   // poll the enable bit before each command
   task automatic do_spm(input logic [7:0] cmd);
      poll_idle();
      wr(`SPF_ADDR_CTRL, {8'h00, cmd});
      repeat (7) @(negedge clk_i);
   endtask
   task automatic buf_byte(input logic [15:0] p, input logic [7:0] e);
      wr(`SPF_ADDR_POINTER, p);
      rd(`SPF_ADDR_DATA, d);
      chk({8'h00, d[7:0]}, {8'h00, e});
   endtask
   initial begin
      #(100000 * 40);
      err_count++;
      conclude();
   end
   initial begin
      {clk_i, nrst_i, wr_i, rd_i, ee, addr_i, wdata_i, fetch_addr_i} = '0;
      {err_count, n_compared} = '0;
      dly = 3'h3;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({15'h0, fetch_allowed_o}, 16'h0001);
      chk({8'h00, lock_data_o}, 16'h00FF);
      // every boot size code, read back too
      for (int s = 0; s < 4; s++) begin
         wr(`SPF_ADDR_CONFIG, {14'h0, 2'(s)});
         rd(`SPF_ADDR_REGION, d);
         chk({3'h0, boot_start_o}, 16'h2000 - (16'h0080 << (3 - s)));
         chk(d, 16'h2000 - (16'h0080 << (3 - s)));
      end
      rd(4'hF, d);
      chk(d, 16'h0000);
      wr(`SPF_ADDR_POINTER, 16'hD280);
      do_spm(`SPF_CMD_ERASE);
      chk({9'h0, flash_page_o}, 16'h0025);
      chk({15'h0, fetch_allowed_o}, 16'h0000);
      @(posedge clk_i);
      fetch_addr_i <= 13'h1C00;
      rd(`SPF_ADDR_CTRL, d);
      chk({15'h0, d[`SPF_BIT_BUSY]}, 16'h0001);
      chk({15'h0, fetch_allowed_o}, 16'h0001);
      poll_idle();
      chk({15'h0, d[`SPF_BIT_BUSY]}, 16'h0001);
      do_spm(`SPF_CMD_REEN);
      poll_idle();
      chk({15'h0, d[`SPF_BIT_BUSY]}, 16'h0000);
      // Word 5 loaded, word 6 left blank, high byte via bit 0
      wr(`SPF_ADDR_POINTER, 16'h000A);
      wr(`SPF_ADDR_DATA, 16'hA55A);
      do_spm(`SPF_CMD_LOAD);
      poll_idle();
      buf_byte(16'h000A, 8'h5A);
      buf_byte(16'hC00B, 8'hA5);
      buf_byte(16'h000C, 8'hFF);
      wr(`SPF_ADDR_POINTER, 16'h1280);
      do_spm(8'h80 | `SPF_CMD_WRITE);
      chk({15'h0, flash_write_o}, 16'h0001);
      chk({9'h0, flash_page_o}, 16'h0025);
      poll_idle();
      buf_byte(16'h000A, 8'hFF);
      do_spm(`SPF_CMD_REEN);
      // Lock write leaves busy clear
      wr(`SPF_ADDR_DATA, 16'h00C3);
      do_spm(`SPF_CMD_LOCK);
      chk({15'h0, lock_write_o}, 16'h0001);
      chk({8'h00, lock_data_o}, 16'h00C3);
      poll_idle();
      chk({15'h0, d[`SPF_BIT_BUSY]}, 16'h0000);
      // Armed write with no store pulse expires
      @(posedge clk_i);
      dly <= 3'h0;
      do_spm(`SPF_CMD_ERASE);
      chk({15'h0, flash_erase_o}, 16'h0000);
      rd(`SPF_ADDR_CTRL, d);
      chk({15'h0, d[`SPF_BIT_OP_EN]}, 16'h0000);
      // control write refused while EEPROM busy
      @(posedge clk_i);
      dly <= 3'h1;
      ee  <= 1'b1;
      repeat (3) @(posedge clk_i);
      wr(`SPF_ADDR_CTRL, {8'h00, `SPF_CMD_ERASE});
      repeat (7) @(negedge clk_i);
      chk({15'h0, flash_erase_o}, 16'h0000);
      @(posedge clk_i);
      ee <= 1'b0;
      // Buffer cleared by a mid-run reset
      wr(`SPF_ADDR_POINTER, 16'h000A);
      wr(`SPF_ADDR_DATA, 16'h1234);
      do_spm(`SPF_CMD_LOAD);
      poll_idle();
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({3'h0, boot_start_o}, 16'h1C00);
      buf_byte(16'h000A, 8'hFF);
      conclude();
   end
endmodule
